// file: rtl/drbs_pkg.sv
// Package for the reset and boot-select block: boot sources, vector
// preset, link DMA preset counts and widths.
// Assumes one 20 MHz clock and an active-low asynchronous reset.
package drbs_pkg;

  localparam int CLK_MHZ = 20;
  localparam int LINK_CH = 4;
  localparam int IRQ_N = 4;
  localparam int ADDR_W = 8;
  localparam int VEC_W = 32;

  // Link boot block: 256 words into internal words 0 to 255
  localparam logic [ADDR_W-1:0] LINK_FIRST_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] LINK_LAST_ADDR = 8'hff;
  localparam logic [ADDR_W:0] LINK_BLOCK_WORDS = 9'h100;

  // Reset vector for link DMA completion interrupts
  localparam logic [VEC_W-1:0] LINK_VEC_RESET = 32'h0000_0000;

  // Core soft-reset pulse length in cycles
  localparam logic [3:0] SOFT_RST_CYCLES = 4'h4;

  // Boot-source select code width
  localparam int BOOT_SEL_W = 2;

  typedef enum logic [1:0] {
    DRBS_BOOT_EPROM,
    DRBS_BOOT_MASTER,
    DRBS_BOOT_LINK,
    DRBS_BOOT_NONE
  } drbs_boot_t;

  typedef enum logic [1:0] {
    DRBS_CORE_RESET,
    DRBS_CORE_IDLE,
    DRBS_CORE_RUN
  } drbs_core_t;

endpackage : drbs_pkg

// file: rtl/drbs_link_dma.sv
// One receive link DMA channel preset to load a 256-word boot block.
// Assumes the link receiver presents one word per rx_valid pulse.
`timescale 1ns/1ns
module drbs_link_dma
  import drbs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic arm,
  input wire logic rx_valid,
  output logic wr_en,
  output logic [ADDR_W-1:0] wr_addr,
  output logic done_irq
);

  typedef struct packed {
    logic active;
    logic [ADDR_W-1:0] addr;
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic done;
  } drbs_dma_st_t;

  drbs_dma_st_t st_r;
  drbs_dma_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.wr_en = 1'b0;
    st_nxt.done = 1'b0;
    if (arm) begin
      st_nxt.active = 1'b1;
      st_nxt.addr = LINK_FIRST_ADDR;
    end else if (st_r.active && rx_valid) begin
      st_nxt.wr_en = 1'b1;
      st_nxt.wr_addr = st_r.addr;
      if (st_r.addr == LINK_LAST_ADDR) begin
        st_nxt.active = 1'b0;
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.addr = st_r.addr + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wr_en = st_r.wr_en;
  assign wr_addr = st_r.wr_addr;
  assign done_irq = st_r.done;

endmodule // drbs_link_dma

// file: rtl/drbs_reset_boot.sv
// Reset and boot-mode control for a DSP core: reset levels, core-only
// soft reset, boot-source straps, link boot DMA preset and idle exit.
// Assumes board logic holds reset_n low until straps are stable.
//
// Operation
// - Soft-reset bit resets the core only, not external port or I/O.
// - Low boot-memory-select strap selects EPROM boot by default.
// - Master boot lets any cluster bus master write memory or DMA.
// - All four receive link DMA channels preset for words 0 to 255.
// - Each link channel raises its interrupt after its final word.
// - Link DMA completion vectors reset to address zero.
// - No-boot mode starts from external memory on any external IRQ.
// - Core leaves every reset idle, running only after an interrupt.
// - Boot-related vector entries are initialised and enabled at reset.
// - During reset the boot-memory-select pin is read as a strap.
// - In EPROM boot boot_memory_select stays asserted during the load.
`timescale 1ns/1ns
module drbs_reset_boot
  import drbs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic eprom_boot_strap,
  input wire logic [BOOT_SEL_W-1:0] boot_mode_strap,
  input wire logic core_soft_reset_bit,
  input wire logic [IRQ_N-1:0] external_interrupt_inputs_n,
  input wire logic [LINK_CH-1:0] link_rx_valid,
  input wire logic eprom_load_done,
  input wire logic master_dma_irq,
  output logic boot_memory_select_n_o,
  output logic boot_memory_select_oe,
  output logic [1:0] boot_source,
  output logic core_reset_n,
  output logic core_running,
  output logic core_idle,
  output logic [VEC_W-1:0] core_start_vector,
  output logic ext_start,
  output logic master_access_en,
  output logic [LINK_CH-1:0] link_wr_en,
  output logic [LINK_CH*ADDR_W-1:0] link_wr_addr,
  output logic [LINK_CH-1:0] link_done_irq,
  output logic [LINK_CH-1:0] link_irq_enabled
);

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers for the interrupt and soft-reset pins
  logic [IRQ_N-1:0] irq_s1_r;
  logic [IRQ_N-1:0] irq_s2_r;
  logic [1:0] srst_sync_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_s1_r <= '1;
      irq_s2_r <= '1;
      srst_sync_r <= 2'h0;
    end else begin
      irq_s1_r <= external_interrupt_inputs_n;
      irq_s2_r <= irq_s1_r;
      srst_sync_r <= {srst_sync_r[0], core_soft_reset_bit};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Strap synchronisers, one per strap bit
  // No reset here: they keep sampling while reset_n is low, so the
  // settled straps are through both flops when release captures them
  logic [BOOT_SEL_W:0] strap_pin;
  logic [BOOT_SEL_W:0] strap_sync;

  assign strap_pin = {boot_mode_strap, eprom_boot_strap};

  genvar si;
  generate
    for (si = 0; si <= BOOT_SEL_W; si++) begin : g_strap
      logic [1:0] sync_r;
      always_ff @(posedge clk) begin
        sync_r <= {sync_r[0], strap_pin[si]};
      end
      assign strap_sync[si] = sync_r[1];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic captured;
    drbs_boot_t boot;
    drbs_core_t core;
    logic [3:0] srst_cnt;
    logic srst_prev;
    logic link_arm;
    logic eprom_busy;
    logic [VEC_W-1:0] vec;
    logic ext_start;
    logic [LINK_CH-1:0] irq_en;
  } drbs_st_t;

  drbs_st_t st_r;
  drbs_st_t st_nxt;

  logic [LINK_CH-1:0] dma_done;
  logic any_irq;
  logic wake;
  logic srst_rise;
  logic eprom_sel;
  logic noboot_sel;

  assign any_irq = ~&irq_s2_r;
  assign srst_rise = srst_sync_r[1] & ~st_r.srst_prev;
  assign eprom_sel = (st_r.boot == DRBS_BOOT_EPROM);
  assign noboot_sel = (st_r.boot == DRBS_BOOT_NONE);
  assign wake = (|(dma_done & st_r.irq_en)) | master_dma_irq |
                (any_irq & noboot_sel);

  always_comb begin
    st_nxt = st_r;
    st_nxt.link_arm = 1'b0;
    st_nxt.ext_start = 1'b0;
    st_nxt.srst_prev = srst_sync_r[1];
    if (!st_r.captured) begin
      // First cycle after release: capture straps once
      st_nxt.captured = 1'b1;
      if (!strap_sync[0]) begin
        st_nxt.boot = DRBS_BOOT_EPROM;
      end else begin
        st_nxt.boot = drbs_boot_t'(strap_sync[BOOT_SEL_W:1]);
      end
      st_nxt.eprom_busy = ~strap_sync[0];
      st_nxt.link_arm = 1'b1;
      st_nxt.vec = LINK_VEC_RESET;
      st_nxt.irq_en = '1;
      st_nxt.core = DRBS_CORE_IDLE;
    end else begin
      if (eprom_load_done) begin
        st_nxt.eprom_busy = 1'b0;
      end
      unique case (st_r.core)
        DRBS_CORE_RESET: begin
          if (st_r.srst_cnt == 4'h0) begin
            st_nxt.core = DRBS_CORE_IDLE;
            st_nxt.vec = LINK_VEC_RESET;
            st_nxt.irq_en = '1;
          end else begin
            st_nxt.srst_cnt = st_r.srst_cnt - 4'h1;
          end
        end
        DRBS_CORE_IDLE: begin
          if (wake) begin
            st_nxt.core = DRBS_CORE_RUN;
            st_nxt.ext_start = any_irq & noboot_sel;
          end
        end
        DRBS_CORE_RUN: begin
        end
        default: begin
          st_nxt.core = DRBS_CORE_IDLE;
        end
      endcase
      // Soft reset wins over a wake in the same cycle
      if (srst_rise) begin
        st_nxt.core = DRBS_CORE_RESET;
        st_nxt.srst_cnt = SOFT_RST_CYCLES - 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '{
        captured: 1'b0,
        boot: DRBS_BOOT_EPROM,
        core: DRBS_CORE_RESET,
        srst_cnt: 4'h0,
        srst_prev: 1'b0,
        link_arm: 1'b0,
        eprom_busy: 1'b0,
        vec: LINK_VEC_RESET,
        ext_start: 1'b0,
        irq_en: '0
      };
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive link DMA channels
  genvar gi;
  generate
    for (gi = 0; gi < LINK_CH; gi++) begin : g_link
      drbs_link_dma u_dma (
        .clk(clk),
        .reset_n(reset_n),
        .arm(st_r.link_arm),
        .rx_valid(link_rx_valid[gi]),
        .wr_en(link_wr_en[gi]),
        .wr_addr(link_wr_addr[gi*ADDR_W +: ADDR_W]),
        .done_irq(dma_done[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  // Pin is only an input strap during reset; driven low while EPROM loads
  assign boot_memory_select_oe = st_r.captured;
  assign boot_memory_select_n_o = ~(st_r.eprom_busy & eprom_sel);
  assign boot_source = st_r.boot;
  assign core_reset_n = (st_r.core != DRBS_CORE_RESET);
  assign core_running = (st_r.core == DRBS_CORE_RUN);
  assign core_idle = (st_r.core == DRBS_CORE_IDLE);
  assign core_start_vector = st_r.vec;
  assign ext_start = st_r.ext_start;
  assign master_access_en = st_r.captured &
                            (st_r.boot == DRBS_BOOT_MASTER);
  assign link_done_irq = dma_done;
  assign link_irq_enabled = st_r.irq_en;

endmodule // drbs_reset_boot

// file: dv/drbs_checker.sv
// Checker bound to the reset and boot block.
// Assumes one clock domain and the block's own port names.
`timescale 1ns/1ns
module drbs_checker
  import drbs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic boot_memory_select_n_o,
  input wire logic [1:0] boot_source,
  input wire logic core_reset_n,
  input wire logic core_running,
  input wire logic [VEC_W-1:0] core_start_vector,
  input wire logic ext_start,
  input wire logic master_access_en,
  input wire logic [LINK_CH-1:0] link_wr_en,
  input wire logic [LINK_CH*ADDR_W-1:0] link_wr_addr,
  input wire logic [LINK_CH-1:0] link_done_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_held; !core_reset_n [*4]; endsequence
  sequence s_back; s_held ##1 core_reset_n; endsequence
  property p_soft; $fell(core_reset_n) |-> s_back; endproperty
  a_soft: assert property (p_soft) else $error("soft");
  property p_idle; $rose(core_reset_n) |-> !core_running; endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_vec;
    $rose(core_reset_n) |-> core_start_vector == LINK_VEC_RESET;
  endproperty
  a_vec: assert property (p_vec) else $error("vector");
  property p_last; link_done_irq[0] |-> link_wr_en[0] &&
    link_wr_addr[ADDR_W-1:0] == LINK_LAST_ADDR; endproperty
  a_last: assert property (p_last) else $error("last");
  property p_bms;
    $fell(boot_memory_select_n_o) |-> boot_source == DRBS_BOOT_EPROM;
  endproperty
  a_bms: assert property (p_bms) else $error("select");
  property p_none;
    ext_start |-> boot_source == DRBS_BOOT_NONE ##[0:1] core_running;
  endproperty
  a_none: assert property (p_none) else $error("noboot");
  property p_mst; master_access_en |-> boot_source == DRBS_BOOT_MASTER;
  endproperty
  a_mst: assert property (p_mst) else $error("master");
  property p_hold; core_running |=> $stable(boot_source); endproperty
  a_hold: assert property (p_hold) else $error("strap");
endmodule // drbs_checker
////////////////////////////////////////////////////////////////////////////
bind drbs_reset_boot drbs_checker drbs_checker_i (
  .clk(clk),
  .reset_n(reset_n),
  .boot_memory_select_n_o(boot_memory_select_n_o),
  .boot_source(boot_source),
  .core_reset_n(core_reset_n),
  .core_running(core_running),
  .core_start_vector(core_start_vector),
  .ext_start(ext_start),
  .master_access_en(master_access_en),
  .link_wr_en(link_wr_en),
  .link_wr_addr(link_wr_addr),
  .link_done_irq(link_done_irq)
);

// file: dv/drbs_link_peer.sv
// Link peer: streams 258 words into all four receive channels.
// Assumes go pulses only after the channels are armed.
`timescale 1ns/1ns
module drbs_link_peer
  import drbs_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  output logic [LINK_CH-1:0] link_rx_valid
);
  int n = 0;
  // Two words past the block end probe refusal
  always @(posedge clk) begin
    n <= go ? 258 : (n > 0 ? n - 1 : 0);
    link_rx_valid <= (n > 0) ? 4'hf : 4'h0;
  end
endmodule // drbs_link_peer

// file: dv/dsp_reset_and_boot_select_bench.sv
// Bench for the reset and boot block, one task per scenario.
// Assumes the link peer model drives the receive strobes.
`timescale 1ns/1ns
module dsp_reset_and_boot_select_bench;
  import drbs_pkg::*;
  logic clk = 1'h0, reset_n = 1'h0, eprom_boot_strap = 1'h0, go = 1'h0;
  logic core_soft_reset_bit = 1'h0, eprom_load_done = 1'h0;
  logic master_dma_irq = 1'h0;
  logic [1:0] boot_mode_strap = 2'h0, boot_source;
  logic [3:0] external_interrupt_inputs_n = 4'hf, link_rx_valid;
  logic [3:0] link_wr_en, link_done_irq, link_irq_enabled;
  logic boot_memory_select_n_o, boot_memory_select_oe, core_reset_n;
  logic core_running, core_idle, ext_start, master_access_en;
  logic [31:0] core_start_vector, link_wr_addr;
  int err_count = 0, compares = 0, n_wr = 0, c0, i;
  drbs_reset_boot drbs_reset_boot_i (
    .clk(clk),
    .reset_n(reset_n),
    .eprom_boot_strap(eprom_boot_strap),
    .boot_mode_strap(boot_mode_strap),
    .core_soft_reset_bit(core_soft_reset_bit),
    .external_interrupt_inputs_n(external_interrupt_inputs_n),
    .link_rx_valid(link_rx_valid),
    .eprom_load_done(eprom_load_done),
    .master_dma_irq(master_dma_irq),
    .boot_memory_select_n_o(boot_memory_select_n_o),
    .boot_memory_select_oe(boot_memory_select_oe),
    .boot_source(boot_source),
    .core_reset_n(core_reset_n),
    .core_running(core_running),
    .core_idle(core_idle),
    .core_start_vector(core_start_vector),
    .ext_start(ext_start),
    .master_access_en(master_access_en),
    .link_wr_en(link_wr_en),
    .link_wr_addr(link_wr_addr),
    .link_done_irq(link_done_irq),
    .link_irq_enabled(link_irq_enabled)
  );
  drbs_link_peer drbs_link_peer_i (
    .clk(clk),
    .go(go),
    .link_rx_valid(link_rx_valid)
  );
  always #25 clk = ~clk;
  always @(posedge clk) if (link_wr_en[0] === 1'h1) n_wr <= n_wr + 1;
////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic hrst(input logic s, input logic [1:0] m);
    @(posedge clk) reset_n <= 1'h0;
    eprom_boot_strap <= s;
    boot_mode_strap <= m;
    repeat (8) @(posedge clk);
    reset_n <= 1'h1;
    repeat (4) @(negedge clk);
  endtask
////////////////////////////////////////////////////////////////////////////
  task automatic t_eprom;
    hrst(1'h0, 2'h2);
    chk(boot_source, DRBS_BOOT_EPROM);
    chk({core_idle, core_running}, 2'h2);
    chk({boot_memory_select_n_o, boot_memory_select_oe}, 2'h1);
    @(posedge clk) eprom_load_done <= 1'h1;
    @(posedge clk) eprom_load_done <= 1'h0;
    repeat (2) @(negedge clk);
    chk(boot_memory_select_n_o, 1'h1);
  endtask
  task automatic t_link;
    hrst(1'h1, 2'h2);
    chk(link_irq_enabled, 4'hf);
    chk(core_start_vector, LINK_VEC_RESET);
    c0 = n_wr;
    @(posedge clk) go <= 1'h1;
    @(posedge clk) go <= 1'h0;
    for (i = 0; i < 300 && link_done_irq[0] !== 1'h1; i++) @(negedge clk);
    chk(link_done_irq, 4'hf);
    chk(link_wr_addr, {4{LINK_LAST_ADDR}});
    repeat (8) @(negedge clk);
    chk(n_wr - c0, LINK_BLOCK_WORDS);
    chk(core_running, 1'h1);
  endtask
  task automatic t_none;
    hrst(1'h1, 2'h3);
    chk(core_running, 1'h0);
    @(posedge clk) external_interrupt_inputs_n <= 4'hb;
    for (i = 0; i < 8 && ext_start !== 1'h1; i++) @(negedge clk);
    chk(ext_start, 1'h1);
    @(posedge clk) external_interrupt_inputs_n <= 4'hf;
    @(negedge clk);
    chk(core_running, 1'h1);
  endtask
  task automatic t_soft;
    @(posedge clk) core_soft_reset_bit <= 1'h1;
    for (i = 0; i < 8 && core_reset_n !== 1'h0; i++) @(negedge clk);
    chk({core_reset_n, boot_memory_select_oe}, 2'h1);
    repeat (8) @(negedge clk);
    chk(boot_source, DRBS_BOOT_NONE);
    chk({core_idle, core_running}, 2'h2);
    @(posedge clk) core_soft_reset_bit <= 1'h0;
  endtask
  task automatic t_master;
    hrst(1'h1, 2'h1);
    chk(master_access_en, 1'h1);
    chk(boot_source, DRBS_BOOT_MASTER);
    chk({core_idle, core_running}, 2'h2);
    @(posedge clk) master_dma_irq <= 1'h1;
    @(posedge clk) master_dma_irq <= 1'h0;
    @(negedge clk);
    chk(core_running, 1'h1);
  endtask
  initial begin
    t_eprom();
    t_link();
    t_none();
    t_soft();
    t_master();
    wrap_up();
  end
  initial begin
    #100000;
    err_count++;
    wrap_up();
  end
endmodule // dsp_reset_and_boot_select_bench
